// >>> inc/sps_pkg.sv
// Constants for the supply supervisor and power mode block.
// Assumes a 125 MHz system clock; comparator inputs are raw digital levels.
package sps_pkg;
  localparam int    CLK_MHZ          = 125;
  localparam real   STARTUP_TIME_MS  = 3.3;
  localparam int    STARTUP_CYCLES   = int'(STARTUP_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int    STARTUP_W        = 20;

  // Brownout levels from nonvolatile options
  localparam int    BOR_LEVELS       = 5;
  localparam int    BOR_SEL_W        = 3;
  localparam logic [BOR_SEL_W-1:0] BOR_SEL_MAX = 3'h4;

  // Supply monitor levels
  localparam int    PVL_LEVELS       = 7;
  localparam int    PVL_SEL_W        = 3;
  localparam logic [PVL_SEL_W-1:0] PVL_SEL_MAX = 3'h6;

  // Frequency limits in kHz per voltage range
  localparam int    FREQ_W           = 16;
  localparam logic [FREQ_W-1:0] R1_MAX_KHZ = 16'h7D00; // 32000
  localparam logic [FREQ_W-1:0] R1_WS_KHZ  = 16'h3E80; // 16000
  localparam logic [FREQ_W-1:0] R2_MAX_KHZ = 16'h3E80; // 16000
  localparam logic [FREQ_W-1:0] R2_WS_KHZ  = 16'h1F40; // 8000
  localparam logic [FREQ_W-1:0] R3_MAX_KHZ = 16'h1068; // 4200
  localparam logic [FREQ_W-1:0] R3_WS_KHZ  = 16'h0834; // 2100

  typedef enum logic [1:0] {
    SPS_RANGE1 = 2'h1,
    SPS_RANGE2 = 2'h2,
    SPS_RANGE3 = 2'h3
  } sps_range_e;

  typedef enum logic [2:0] {
    SPS_RUN      = 3'h0,
    SPS_LP_RUN   = 3'h1,
    SPS_SLEEP    = 3'h2,
    SPS_LP_SLEEP = 3'h3,
    SPS_STOP     = 3'h4,
    SPS_STANDBY  = 3'h5
  } sps_pmode_e;

  typedef enum logic [1:0] {
    SPS_REG_MAIN = 2'h0,
    SPS_REG_LOWP = 2'h1,
    SPS_REG_OFF  = 2'h2
  } sps_regmode_e;

  typedef enum logic [1:0] {
    SPS_BOOT_FLASH  = 2'h0,
    SPS_BOOT_SYSMEM = 2'h1,
    SPS_BOOT_RAM    = 2'h3
  } sps_boot_e;

  typedef enum logic [1:0] {
    SPS_ST_HELD  = 2'h0,
    SPS_ST_WAIT  = 2'h1,
    SPS_ST_READY = 2'h2
  } sps_rst_e;
endpackage : sps_pkg

// >>> hw/sps_sync.sv
// Two-flop level synchroniser.
// Input may be asynchronous; output is a clean level in the CLK domain.
`timescale 1ns/1ns
module sps_sync
  import sps_pkg::*;
(
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic CE,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  always_comb begin
    meta_next = meta_reg;
    q_next    = q_reg;
    if (SRST) begin
      meta_next = 1'b0;
      q_next    = 1'b0;
    end else if (CE) begin
      meta_next = d;
      q_next    = meta_reg;
    end
  end

  always_ff @(posedge CLK) begin
    meta_reg <= meta_next;
    q_reg    <= q_next;
  end

  assign q = q_reg;
endmodule : sps_sync

// >>> hw/sps_freq_limit.sv
// Core clock limit and flash wait state per voltage range.
// Frequency request arrives in kHz from the clock controller.
`timescale 1ns/1ns
module sps_freq_limit
  import sps_pkg::*;
(
  input  wire logic [1:0]        range_sel,
  input  wire logic [FREQ_W-1:0] freq_khz,
  output logic                   freq_ok,
  output logic                   wait_state
);
  logic [FREQ_W-1:0] max_khz;
  logic [FREQ_W-1:0] ws_khz;

  always_comb begin
    case (range_sel)
      SPS_RANGE1: begin
        max_khz = R1_MAX_KHZ;
        ws_khz  = R1_WS_KHZ;
      end
      SPS_RANGE2: begin
        max_khz = R2_MAX_KHZ;
        ws_khz  = R2_WS_KHZ;
      end
      SPS_RANGE3: begin
        max_khz = R3_MAX_KHZ;
        ws_khz  = R3_WS_KHZ;
      end
      default: begin
        max_khz = R3_MAX_KHZ;
        ws_khz  = R3_WS_KHZ;
      end
    endcase
    freq_ok    = (freq_khz <= max_khz);
    wait_state = (freq_khz > ws_khz);
  end
endmodule : sps_freq_limit

// >>> hw/sps_supervisor.sv
// Supply supervisor: reset hold, brownout, supply monitor, regulator modes.
// Assumes analog comparators deliver levels; boot pins and options are static at start.
// Summary of operation
// - Reset is held while the supply is under the power-on or brownout threshold.
// - Brownout level is one of five, taken from the nonvolatile option input only.
// - The supply monitor compares against one of seven software-chosen levels.
// - Monitor interrupts can fire on falling, rising or both crossings.
// - The supply monitor stays idle until software enables it.
// - When selected, the internal reference is switched off during Stop.
// - Main regulation in Run and Sleep, low-power regulation in low-power run, low-power sleep and Stop.
// - In Standby the regulator is off and only standby circuitry is retained.
// - Reset is released about 3.3 ms after the supply becomes good.
// - Boot pins are sampled at startup to pick flash, system memory or RAM.
// - Range 2 limits the core clock to 16 MHz with one wait state above 8 MHz.
// - Range 3 limits the core clock to 4.2 MHz with one wait state above 2.1 MHz.
// - Range 1 limits the core clock to 32 MHz with one wait state above 16 MHz.
`timescale 1ns/1ns
module sps_supervisor
  import sps_pkg::*;
#(
  parameter int STARTUP_CNT = STARTUP_CYCLES
)
(
  input  wire logic                 CLK,
  input  wire logic                 SRST,
  input  wire logic                 CE,
  input  wire logic                 POWER_ON_ABOVE,
  input  wire logic [BOR_LEVELS-1:0] BROWNOUT_ABOVE,
  input  wire logic [BOR_SEL_W-1:0] BOR_OPTION,
  input  wire logic                 BOR_OPTION_EN,
  input  wire logic [PVL_LEVELS-1:0] MONITOR_ABOVE,
  input  wire logic                 MONITOR_EN,
  input  wire logic [PVL_SEL_W-1:0] MONITOR_LEVEL_SEL,
  input  wire logic                 MONITOR_RISE_EN,
  input  wire logic                 MONITOR_FALL_EN,
  input  wire logic                 MONITOR_FLAG_CLR,
  input  wire logic                 REF_OFF_IN_STOP,
  input  wire logic [2:0]           POWER_MODE,
  input  wire logic [1:0]           BOOT_PINS,
  input  wire logic [1:0]           RANGE_SEL,
  input  wire logic [FREQ_W-1:0]    FREQ_KHZ,
  output logic                      CHIP_RESET,
  output logic                      MONITOR_OUT,
  output logic                      MONITOR_RISE_FLAG,
  output logic                      MONITOR_FALL_FLAG,
  output logic                      MONITOR_IRQ,
  output logic                      REF_ENABLE,
  output logic [1:0]                REGULATOR_MODE,
  output logic                      CORE_RETAIN,
  output logic [1:0]                BOOT_SOURCE,
  output logic                      BOOT_VALID,
  output logic                      FREQ_OK,
  output logic                      FLASH_WAIT
);
  // Synchronised comparator levels
  logic                  por_s;
  logic [BOR_LEVELS-1:0] bor_s;
  logic [PVL_LEVELS-1:0] pvl_s;

  sps_sync u_por (
    .CLK  (CLK),
    .SRST (SRST),
    .CE   (CE),
    .d    (POWER_ON_ABOVE),
    .q    (por_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < BOR_LEVELS; gi++) begin : g_bor
      sps_sync u_s (
        .CLK  (CLK),
        .SRST (SRST),
        .CE   (CE),
        .d    (BROWNOUT_ABOVE[gi]),
        .q    (bor_s[gi])
      );
    end
    for (gi = 0; gi < PVL_LEVELS; gi++) begin : g_pvl
      sps_sync u_s (
        .CLK  (CLK),
        .SRST (SRST),
        .CE   (CE),
        .d    (MONITOR_ABOVE[gi]),
        .q    (pvl_s[gi])
      );
    end
  endgenerate

  // Supply good: power-on comparator and selected brownout comparator
  logic [BOR_SEL_W-1:0] bor_sel;
  logic                 supply_good;
  always_comb begin
    bor_sel     = (BOR_OPTION > BOR_SEL_MAX) ? BOR_SEL_MAX : BOR_OPTION;
    supply_good = por_s && (!BOR_OPTION_EN || bor_s[bor_sel]);
  end

  // Reset sequencer
  sps_rst_e             st_reg;
  sps_rst_e             st_next;
  logic [STARTUP_W-1:0] cnt_reg;
  logic [STARTUP_W-1:0] cnt_next;
  logic                 rst_reg;
  logic                 rst_next;
  logic [1:0]           boot_reg;
  logic [1:0]           boot_next;
  logic                 bvalid_reg;
  logic                 bvalid_next;

  always_comb begin
    st_next     = st_reg;
    cnt_next    = cnt_reg;
    rst_next    = rst_reg;
    boot_next   = boot_reg;
    bvalid_next = bvalid_reg;
    if (SRST) begin
      st_next     = SPS_ST_HELD;
      cnt_next    = '0;
      rst_next    = 1'b1;
      boot_next   = SPS_BOOT_FLASH;
      bvalid_next = 1'b0;
    end else if (CE) begin
      case (st_reg)
        SPS_ST_HELD: begin
          rst_next    = 1'b1;
          bvalid_next = 1'b0;
          cnt_next    = '0;
          if (supply_good) begin
            st_next = SPS_ST_WAIT;
          end
        end
        SPS_ST_WAIT: begin
          if (!supply_good) begin
            st_next = SPS_ST_HELD;
          end else if (cnt_reg >= STARTUP_W'(STARTUP_CNT - 1)) begin
            st_next     = SPS_ST_READY;
            rst_next    = 1'b0;
            boot_next   = BOOT_PINS[0] ? (BOOT_PINS[1] ? SPS_BOOT_RAM : SPS_BOOT_SYSMEM)
                                       : SPS_BOOT_FLASH;
            bvalid_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        SPS_ST_READY: begin
          if (!supply_good) begin
            st_next     = SPS_ST_HELD;
            rst_next    = 1'b1;
            bvalid_next = 1'b0;
          end
        end
        default: begin
          st_next  = SPS_ST_HELD;
          rst_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    st_reg     <= st_next;
    cnt_reg    <= cnt_next;
    rst_reg    <= rst_next;
    boot_reg   <= boot_next;
    bvalid_reg <= bvalid_next;
  end

  // Supply monitor with crossing flags
  logic [PVL_SEL_W-1:0] pvl_sel;
  logic                 pvl_lvl;
  logic                 mon_reg;
  logic                 mon_next;
  logic                 armed_reg;
  logic                 armed_next;
  logic                 rise_reg;
  logic                 rise_next;
  logic                 fall_reg;
  logic                 fall_next;
  logic                 irq_reg;
  logic                 irq_next;

  always_comb begin
    pvl_sel    = (MONITOR_LEVEL_SEL > PVL_SEL_MAX) ? PVL_SEL_MAX : MONITOR_LEVEL_SEL;
    pvl_lvl    = pvl_s[pvl_sel];
    mon_next   = mon_reg;
    armed_next = armed_reg;
    rise_next  = rise_reg;
    fall_next  = fall_reg;
    irq_next   = irq_reg;
    if (SRST) begin
      mon_next   = 1'b0;
      armed_next = 1'b0;
      rise_next  = 1'b0;
      fall_next  = 1'b0;
      irq_next   = 1'b0;
    end else if (CE) begin
      if (!MONITOR_EN || rst_reg) begin
        armed_next = 1'b0;
        mon_next   = 1'b0;
      end else begin
        armed_next = 1'b1;
        mon_next   = pvl_lvl;
      end
      if (MONITOR_FLAG_CLR) begin
        rise_next = 1'b0;
        fall_next = 1'b0;
      end
      // Set wins over clear
      if (armed_reg && MONITOR_EN && !rst_reg && pvl_lvl && !mon_reg) begin
        rise_next = 1'b1;
      end
      if (armed_reg && MONITOR_EN && !rst_reg && !pvl_lvl && mon_reg) begin
        fall_next = 1'b1;
      end
      irq_next = (rise_next && MONITOR_RISE_EN) || (fall_next && MONITOR_FALL_EN);
    end
  end

  always_ff @(posedge CLK) begin
    mon_reg   <= mon_next;
    armed_reg <= armed_next;
    rise_reg  <= rise_next;
    fall_reg  <= fall_next;
    irq_reg   <= irq_next;
  end

  // Regulator, reference and frequency limits
  logic                 fok_c;
  logic                 ws_c;
  logic [1:0]           reg_reg;
  logic [1:0]           reg_next;
  logic                 ref_reg;
  logic                 ref_next;
  logic                 ret_reg;
  logic                 ret_next;
  logic                 fok_reg;
  logic                 fok_next;
  logic                 ws_reg;
  logic                 ws_next;

  sps_freq_limit u_freq (
    .range_sel  (RANGE_SEL),
    .freq_khz   (FREQ_KHZ),
    .freq_ok    (fok_c),
    .wait_state (ws_c)
  );

  always_comb begin
    reg_next = reg_reg;
    ref_next = ref_reg;
    ret_next = ret_reg;
    fok_next = fok_reg;
    ws_next  = ws_reg;
    if (SRST) begin
      reg_next = SPS_REG_MAIN;
      ref_next = 1'b1;
      ret_next = 1'b1;
      fok_next = 1'b0;
      ws_next  = 1'b1;
    end else if (CE) begin
      ret_next = 1'b1;
      ref_next = 1'b1;
      case (POWER_MODE)
        SPS_RUN, SPS_SLEEP: reg_next = SPS_REG_MAIN;
        SPS_LP_RUN, SPS_LP_SLEEP: reg_next = SPS_REG_LOWP;
        SPS_STOP: begin
          reg_next = SPS_REG_LOWP;
          ref_next = !REF_OFF_IN_STOP;
        end
        SPS_STANDBY: begin
          reg_next = SPS_REG_OFF;
          ret_next = 1'b0;
          ref_next = 1'b0;
        end
        default: reg_next = SPS_REG_MAIN;
      endcase
      fok_next = fok_c;
      ws_next  = ws_c;
    end
  end

  always_ff @(posedge CLK) begin
    reg_reg <= reg_next;
    ref_reg <= ref_next;
    ret_reg <= ret_next;
    fok_reg <= fok_next;
    ws_reg  <= ws_next;
  end

  assign CHIP_RESET        = rst_reg;
  assign MONITOR_OUT       = mon_reg;
  assign MONITOR_RISE_FLAG = rise_reg;
  assign MONITOR_FALL_FLAG = fall_reg;
  assign MONITOR_IRQ       = irq_reg;
  assign REF_ENABLE        = ref_reg;
  assign REGULATOR_MODE    = reg_reg;
  assign CORE_RETAIN       = ret_reg;
  assign BOOT_SOURCE       = boot_reg;
  assign BOOT_VALID        = bvalid_reg;
  assign FREQ_OK           = fok_reg;
  assign FLASH_WAIT        = ws_reg;

  // Checks
  sequence s_bad_supply;
    !supply_good && CE;
  endsequence
  sequence s_reset_high;
    ##1 CHIP_RESET;
  endsequence
  chk_reset_on_bad: assert property (@(posedge CLK) disable iff (SRST)
    s_bad_supply |-> s_reset_high) else $error("reset not held on bad supply");
  chk_release_ready: assert property (@(posedge CLK) disable iff (SRST)
    $fell(CHIP_RESET) |-> $past(st_reg) == SPS_ST_WAIT && BOOT_VALID)
    else $error("reset released outside startup wait");
  chk_boot_sampled: assert property (@(posedge CLK) disable iff (SRST)
    $fell(CHIP_RESET) |-> BOOT_SOURCE == ($past(BOOT_PINS) & {$past(BOOT_PINS[0]), 1'b1}))
    else $error("boot source does not match pins");
  chk_monitor_idle: assert property (@(posedge CLK) disable iff (SRST)
    !MONITOR_EN && CE |=> !MONITOR_OUT) else $error("monitor active while disabled");
  chk_irq_masked: assert property (@(posedge CLK) disable iff (SRST)
    MONITOR_IRQ |-> (MONITOR_RISE_FLAG && $past(MONITOR_RISE_EN)) ||
                    (MONITOR_FALL_FLAG && $past(MONITOR_FALL_EN)))
    else $error("irq without enabled flag");
  chk_rise_cause: assert property (@(posedge CLK) disable iff (SRST)
    $rose(MONITOR_RISE_FLAG) |-> $rose(MONITOR_OUT)) else $error("rise flag without crossing");
  chk_stop_ref: assert property (@(posedge CLK) disable iff (SRST)
    CE && POWER_MODE == SPS_STOP && REF_OFF_IN_STOP |=> !REF_ENABLE)
    else $error("reference on in stop");
  chk_standby_off: assert property (@(posedge CLK) disable iff (SRST)
    CE && POWER_MODE == SPS_STANDBY |=> REGULATOR_MODE == SPS_REG_OFF && !CORE_RETAIN)
    else $error("regulator on in standby");
  chk_lp_mode: assert property (@(posedge CLK) disable iff (SRST)
    CE && POWER_MODE == SPS_LP_RUN |=> REGULATOR_MODE == SPS_REG_LOWP)
    else $error("low power regulation missing");
  chk_range2_ws: assert property (@(posedge CLK) disable iff (SRST)
    CE && RANGE_SEL == SPS_RANGE2 && FREQ_KHZ > R2_WS_KHZ |=> FLASH_WAIT)
    else $error("range 2 wait state missing");
endmodule : sps_supervisor

// >>> verif/sps_supply_model.sv
// Far-side model: supply comparators and boot selection pins.
// Assumes the bench gives the supply level in millivolts.
`timescale 1ns/1ns
module sps_supply_model
  import sps_pkg::*;
#(
  parameter int POR_MV     = 1500,
  parameter int BROWN_MV0  = 1800,
  parameter int BROWN_STEP = 300,
  parameter int MON_MV0    = 1850,
  parameter int MON_STEP   = 200
)
(
  input  wire logic                  CLK,
  input  wire logic [15:0]           vdd_mv,
  input  wire logic [1:0]            boot_want,
  input  wire logic                  chip_reset,
  output logic                       por_above,
  output logic [BOR_LEVELS-1:0]      brown_above,
  output logic [PVL_LEVELS-1:0]      mon_above,
  output logic [1:0]                 boot_pins
);
  always_comb begin
    por_above = (int'(vdd_mv) > POR_MV);
    for (int i = 0; i < BOR_LEVELS; i++) begin
      brown_above[i] = (int'(vdd_mv) > BROWN_MV0 + BROWN_STEP * i);
    end
    for (int i = 0; i < PVL_LEVELS; i++) begin
      mon_above[i] = (int'(vdd_mv) > MON_MV0 + MON_STEP * i);
    end
  end

  // Pins held while reset is in force, then left to wander
  always_ff @(posedge CLK) begin
    boot_pins <= chip_reset ? boot_want : ~boot_pins;
  end
endmodule : sps_supply_model

// >>> verif/tb.sv
// Self-checking bench for the supply supervisor.
// Assumes the supply model beside it; startup count shortened to 20 cycles.
`timescale 1ns/1ns
module tb
  import sps_pkg::*;
;
  localparam int SCNT = 20;
  typedef struct {int id; logic [15:0] val;} sps_note_s;
  logic        CLK = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [2:0]  brown_opt = 3'h0;
  logic        brown_en = 1'b0;
  logic        mon_en = 1'b0;
  logic [2:0]  mon_sel = 3'h0;
  logic        rise_en = 1'b0;
  logic        fall_en = 1'b0;
  logic        flag_clr = 1'b0;
  logic        ref_opt = 1'b0;
  logic [2:0]  pmode = 3'h0;
  logic [1:0]  range_sel = 2'h1;
  logic [15:0] freq = 16'h0000;
  logic [15:0] vdd = 16'h0000;
  logic [1:0]  boot_want = 2'h0;
  logic        por_a, chip_rst, mon_out, rise_f, fall_f, irq, ref_en, retain, boot_ok;
  logic        freq_ok, fwait;
  logic [4:0]  brown_a;
  logic [6:0]  mon_a;
  logic [1:0]  boot_pins, reg_mode, boot_src;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  sps_note_s   note_q [$];
  event        sample_ev;
  string       nm [12] = '{"chip_reset", "monitor_out", "rise_flag", "fall_flag", "irq",
                           "ref_enable", "regulator_mode", "core_retain", "boot_source",
                           "boot_valid", "freq_ok", "flash_wait"};
  logic [15:0] rst_val [12] = '{1, 0, 0, 0, 0, 1, 0, 1, 0, 0, 0, 1};
  logic [1:0]  boots [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0]  boot_exp [4] = '{2'h0, 2'h1, 2'h3, 2'h0};

  sps_supervisor #(.STARTUP_CNT(SCNT)) i_dut (
    .CLK(CLK), .SRST(srst), .CE(ce), .POWER_ON_ABOVE(por_a), .BROWNOUT_ABOVE(brown_a),
    .BOR_OPTION(brown_opt), .BOR_OPTION_EN(brown_en), .MONITOR_ABOVE(mon_a),
    .MONITOR_EN(mon_en), .MONITOR_LEVEL_SEL(mon_sel), .MONITOR_RISE_EN(rise_en),
    .MONITOR_FALL_EN(fall_en), .MONITOR_FLAG_CLR(flag_clr), .REF_OFF_IN_STOP(ref_opt),
    .POWER_MODE(pmode), .BOOT_PINS(boot_pins), .RANGE_SEL(range_sel), .FREQ_KHZ(freq),
    .CHIP_RESET(chip_rst), .MONITOR_OUT(mon_out), .MONITOR_RISE_FLAG(rise_f),
    .MONITOR_FALL_FLAG(fall_f), .MONITOR_IRQ(irq), .REF_ENABLE(ref_en),
    .REGULATOR_MODE(reg_mode), .CORE_RETAIN(retain), .BOOT_SOURCE(boot_src),
    .BOOT_VALID(boot_ok), .FREQ_OK(freq_ok), .FLASH_WAIT(fwait));

  sps_supply_model i_supply (
    .CLK(CLK), .vdd_mv(vdd), .boot_want(boot_want), .chip_reset(chip_rst),
    .por_above(por_a), .brown_above(brown_a), .mon_above(mon_a), .boot_pins(boot_pins));

  initial begin
    forever #4 CLK = ~CLK;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(string what, logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [15:0] seen(int id);
    logic [15:0] v [12];
    v = '{chip_rst, mon_out, rise_f, fall_f, irq, ref_en, reg_mode, retain,
          boot_src, boot_ok, freq_ok, fwait};
    return v[id];
  endfunction : seen

  // Output watcher: compares every queued note, oldest first, at each sample point
  initial begin : watch
    sps_note_s n;
    forever begin
      @(sample_ev);
      while (note_q.size() > 0) begin
        n = note_q.pop_front();
        check(nm[n.id], seen(n.id), n.val);
      end
    end
  end

  initial begin
    forever begin
      @(posedge CLK);
      cycles++;
      if (cycles == 3000) begin
        fail_count++;
        give_verdict();
      end
    end
  end

  task automatic cyc(int n);
    repeat (n) @(negedge CLK);
  endtask : cyc

  task automatic expect_out(int id, logic [15:0] v);
    note_q.push_back('{id, v});
  endtask : expect_out

  task automatic sample();
    -> sample_ev;
    #1;
  endtask : sample

  task automatic power_up(logic [15:0] mv);
    int cnt;
    cnt = 0;
    vdd = mv;
    while (chip_rst !== 1'b0 && cnt < 100) begin
      cyc(1);
      cnt++;
    end
    check("startup_time", 16'(cnt >= SCNT && cnt <= SCNT + 6), 16'h0001);
  endtask : power_up

  initial begin : main
    int k, thr, sel;
    logic [15:0] mx, ws;
    logic [15:0] fq [5];
    k = $urandom(43077);
    cyc(2);
    for (int i = 0; i < 12; i++) if (i != 8) expect_out(i, rst_val[i]);
    sample();
    srst = 1'b0;
    foreach (boots[i]) begin
      vdd = 16'h0000;
      boot_want = boots[i];
      cyc(5);
      expect_out(0, 1);
      sample();
      power_up(16'h0CE4);
      cyc(3);
      expect_out(9, 1);
      expect_out(8, boot_exp[i]);
      sample();
    end
    // Brownout at a random option level
    k = $urandom % 5;
    thr = 1800 + 300 * k;
    brown_opt = 3'(k);
    brown_en = 1'b1;
    vdd = 16'(thr - 150);
    cyc(5);
    expect_out(0, 1);
    sample();
    power_up(16'(thr + 150));
    vdd = 16'(thr - 150);
    cyc(5);
    expect_out(0, 1);
    sample();
    brown_en = 1'b0;
    power_up(16'(thr - 150));
    for (int m = 0; m < 6; m++) begin
      for (int o = 0; o < 2; o++) begin
        pmode = 3'(m);
        ref_opt = o[0];
        cyc(3);
        expect_out(6, (m == 0 || m == 2) ? 0 : (m == 5 ? 2 : 1));
        expect_out(5, !((m == 4 && o == 1) || m == 5));
        expect_out(7, m != 5);
        sample();
      end
    end
    pmode = 3'h0;
    for (int r = 0; r < 4; r++) begin
      mx = (r == 1) ? R1_MAX_KHZ : (r == 2) ? R2_MAX_KHZ : R3_MAX_KHZ;
      ws = (r == 1) ? R1_WS_KHZ : (r == 2) ? R2_WS_KHZ : R3_WS_KHZ;
      fq = '{ws, ws + 16'h0001, mx, mx + 16'h0001, 16'($urandom % 40000)};
      foreach (fq[j]) begin
        range_sel = 2'(r);
        freq = fq[j];
        cyc(3);
        expect_out(10, fq[j] <= mx);
        if (fq[j] <= mx) expect_out(11, fq[j] > ws);
        sample();
      end
    end
    // Supply monitor at a random level
    sel = $urandom % 7;
    thr = 1850 + 200 * sel;
    mon_sel = 3'(sel);
    fall_en = 1'b1;
    vdd = 16'(thr - 100);
    cyc(5);
    vdd = 16'(thr + 100);
    cyc(5);
    expect_out(1, 0);
    expect_out(2, 0);
    sample();
    mon_en = 1'b1;
    cyc(5);
    expect_out(1, 1);
    expect_out(2, 0);
    sample();
    vdd = 16'(thr - 100);
    cyc(2);
    expect_out(3, 0);
    sample();
    cyc(1);
    expect_out(3, 1);
    expect_out(4, 1);
    expect_out(1, 0);
    sample();
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    cyc(2);
    expect_out(3, 0);
    expect_out(4, 0);
    sample();
    vdd = 16'(thr + 100);
    cyc(5);
    expect_out(2, 1);
    expect_out(4, 0);
    sample();
    rise_en = 1'b1;
    cyc(3);
    expect_out(4, 1);
    sample();
    // Clock enable low freezes the mode outputs
    ce = 1'b0;
    pmode = 3'h5;
    cyc(3);
    expect_out(6, 0);
    expect_out(7, 1);
    sample();
    ce = 1'b1;
    cyc(2);
    expect_out(6, 2);
    expect_out(7, 0);
    sample();
    give_verdict();
  end
endmodule : tb
